// File: verilog/pmc_pkg.sv
// constants, register map and types of the proximity measurement control block
package pmc_pkg;

  // clock
  localparam int unsigned CLK_MHZ          = 20;
  // time bases
  localparam real         IT_BASE_US       = 12.5;
  localparam real         IT_UNIT_US       = 25.0;
  localparam real         WAIT_UNIT_MS     = 2.5;
  localparam int unsigned IT_BASE_CYC      = int'($ceil(IT_BASE_US * CLK_MHZ));
  localparam int unsigned IT_UNIT_CYC      = int'($ceil(IT_UNIT_US * CLK_MHZ));
  localparam int unsigned WAIT_UNIT_CYC_DEF = int'($ceil(WAIT_UNIT_MS * 1000.0 * CLK_MHZ));
  localparam int unsigned CNT_W            = 24;
  // serial bus address, value arbitrary
  localparam logic [6:0]  DEV_ADDR_DEF     = 7'h3A;

  // command codes
  localparam logic [7:0]  CMD_MEAS         = 8'h00;
  localparam logic [7:0]  CMD_TIME         = 8'h01;
  localparam logic [7:0]  CMD_EMIT         = 8'h02;
  localparam logic [7:0]  CMD_STAT         = 8'h0D;

  // measurement_control fields
  localparam int unsigned ON_BIT           = 0;
  localparam int unsigned MODE_BIT         = 4;
  localparam int unsigned TRIG_BIT         = 5;
  localparam int unsigned CAL_BIT          = 7;
  localparam int unsigned SD_BIT           = 8;
  // integration_time_config fields
  localparam int unsigned WAIT_LSB         = 0;
  localparam int unsigned IT_LSB           = 8;
  // emitter_drive_config fields
  localparam int unsigned CUR_LSB          = 0;
  localparam int unsigned DRV_BIT          = 3;
  // status fields
  localparam int unsigned FIRST_BIT        = 0;
  localparam int unsigned ACTIVE_BIT       = 1;

  // reset values
  localparam logic        ON_RST           = 1'b0;
  localparam logic        MODE_RST         = 1'b0;
  localparam logic        SD_RST           = 1'b1;
  localparam logic [3:0]  IT_RST           = 4'h0;
  localparam logic [7:0]  WAIT_RST         = 8'h00;
  localparam logic [2:0]  CUR_RST          = 3'h0;
  localparam logic        DRV_RST          = 1'b0;
  // first code with the wide count range (200 us)
  localparam logic [3:0]  IT_WIDE_MIN      = 4'h8;
  localparam logic [2:0]  CUR_MIN_VALID    = 3'h2;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_RX   = 3'b001,
    I2C_ACK  = 3'b010,
    I2C_TX   = 3'b011,
    I2C_RACK = 3'b100
  } pmc_i2c_type;

  typedef enum logic [1:0] {
    MS_IDLE   = 2'b00,
    MS_ACTIVE = 2'b01,
    MS_WAIT   = 2'b10
  } pmc_meas_type;

endpackage

// File: verilog/pmc_timer.sv
// down-counting interval timer: done pulses on the last cycle of a loaded interval
`timescale 1ns/10ps
`default_nettype none
module pmc_timer (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic                     load,
  input  wire logic [pmc_pkg::CNT_W-1:0] value,
  output logic                          done
);
  logic [pmc_pkg::CNT_W-1:0] rem_q;
  logic [pmc_pkg::CNT_W-1:0] rem_d;

  // done is combinational so the caller leaves its state exactly on the boundary
  assign done = (rem_q == 24'h000001);

  always_comb begin
    rem_d = rem_q;
    if (load) begin
      rem_d = value;
    end else if (rem_q != 24'h000000) begin
      rem_d = rem_q - 24'h000001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rem_q <= 24'h000000;
    end else begin
      rem_q <= rem_d;
    end
  end
endmodule
`default_nettype wire

// File: verilog/pmc_top.sv
// proximity measurement control: serial register slave, measurement sequencer, emitter timing
`timescale 1ns/10ps
`default_nettype none
module pmc_top #(
  parameter int unsigned WAIT_UNIT_CYC = pmc_pkg::WAIT_UNIT_CYC_DEF,
  parameter logic [6:0]  DEV_ADDR      = pmc_pkg::DEV_ADDR_DEF
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  output logic            sensor_powered,
  output logic            meas_active,
  output logic            meas_done,
  output logic            emitter_pulse,
  output logic [2:0]      emitter_current_code,
  output logic            emitter_current_valid,
  output logic            adc_wide_range,
  output logic            factory_cal_reload,
  output logic            first_detect
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; third stage only remembers the previous level
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_s2_q & ~scl_s3_q;
  assign scl_fall  = ~scl_s2_q & scl_s3_q;
  assign bus_start = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
  assign bus_stop  = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;

  ////////////////////////////////////////////////////////////////////////////
  // serial slave: address, command code, then low and high data bytes
  pmc_pkg::pmc_i2c_type i2c_q, i2c_d;
  logic [7:0]  shift_q, shift_d;
  logic [3:0]  bit_q, bit_d;
  logic [1:0]  byte_q, byte_d;
  logic        rd_q, rd_d;
  logic        hi_q, hi_d;
  logic [7:0]  cmd_q, cmd_d;
  logic [7:0]  lo_q, lo_d;
  logic        wr_en;
  logic        stat_rd;
  logic [15:0] rd_word;

  always_comb begin
    i2c_d   = i2c_q;
    shift_d = shift_q;
    bit_d   = bit_q;
    byte_d  = byte_q;
    rd_d    = rd_q;
    hi_d    = hi_q;
    cmd_d   = cmd_q;
    lo_d    = lo_q;
    wr_en   = 1'b0;
    stat_rd = 1'b0;
    if (bus_start) begin
      i2c_d  = pmc_pkg::I2C_RX;
      bit_d  = 4'h0;
      byte_d = 2'h0;
      hi_d   = 1'b0;
    end else if (bus_stop) begin
      i2c_d = pmc_pkg::I2C_IDLE;
    end else begin
      unique case (i2c_q)
        pmc_pkg::I2C_IDLE: begin
        end
        pmc_pkg::I2C_RX: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_s2_q};
            bit_d   = bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            i2c_d = pmc_pkg::I2C_ACK;
            if (byte_q == 2'h0) begin
              rd_d = shift_q[0];
              if (shift_q[7:1] != DEV_ADDR) begin
                i2c_d = pmc_pkg::I2C_IDLE;
              end
              byte_d = 2'h1;
            end else if (byte_q == 2'h1) begin
              cmd_d  = shift_q;
              byte_d = 2'h2;
            end else if (!hi_q) begin
              lo_d = shift_q;
              hi_d = 1'b1;
            end else begin
              wr_en = 1'b1;
              hi_d  = 1'b0;
            end
          end
        end
        pmc_pkg::I2C_ACK: begin
          if (scl_fall) begin
            bit_d = 4'h0;
            if (rd_q) begin
              i2c_d   = pmc_pkg::I2C_TX;
              shift_d = hi_q ? rd_word[15:8] : rd_word[7:0];
              stat_rd = ~hi_q & (cmd_q == pmc_pkg::CMD_STAT);
            end else begin
              i2c_d = pmc_pkg::I2C_RX;
            end
          end
        end
        pmc_pkg::I2C_TX: begin
          if (scl_fall) begin
            if (bit_q == 4'h7) begin
              i2c_d = pmc_pkg::I2C_RACK;
              hi_d  = ~hi_q;
            end else begin
              shift_d = {shift_q[6:0], 1'b1};
              bit_d   = bit_q + 4'h1;
            end
          end
        end
        pmc_pkg::I2C_RACK: begin
          // master nack ends the read; wait for stop
          if (scl_rise && sda_s2_q) begin
            i2c_d = pmc_pkg::I2C_IDLE;
          end else if (scl_fall) begin
            i2c_d   = pmc_pkg::I2C_TX;
            bit_d   = 4'h0;
            shift_d = hi_q ? rd_word[15:8] : rd_word[7:0];
            stat_rd = ~hi_q & (cmd_q == pmc_pkg::CMD_STAT);
          end
        end
        default: begin
          i2c_d = pmc_pkg::I2C_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      i2c_q   <= pmc_pkg::I2C_IDLE;
      shift_q <= 8'h00;
      bit_q   <= 4'h0;
      byte_q  <= 2'h0;
      rd_q    <= 1'b0;
      hi_q    <= 1'b0;
      cmd_q   <= 8'h00;
      lo_q    <= 8'h00;
    end else begin
      i2c_q   <= i2c_d;
      shift_q <= shift_d;
      bit_q   <= bit_d;
      byte_q  <= byte_d;
      rd_q    <= rd_d;
      hi_q    <= hi_d;
      cmd_q   <= cmd_d;
      lo_q    <= lo_d;
    end
  end

  // open drain: only ever pulls low
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~((i2c_q == pmc_pkg::I2C_ACK) |
                      ((i2c_q == pmc_pkg::I2C_TX) & ~shift_q[7]));

  logic [15:0] wr_word;
  assign wr_word = {shift_q, lo_q};

  ////////////////////////////////////////////////////////////////////////////
  // registers and measurement sequencer
  logic       on_q, on_d, mode_q, mode_d, trig_q, trig_d, cal_q, cal_d, sd_q, sd_d;
  logic [3:0] it_q, it_d;
  logic [7:0] wait_q, wait_d;
  logic [2:0] cur_q, cur_d;
  logic       drv_q, drv_d;
  logic       armed_q, armed_d, first_q, first_d;
  logic       emit_q, emit_d, done_q, done_d;
  pmc_pkg::pmc_meas_type ms_q, ms_d;
  logic                      tmr_load, tmr_done, run_ok;
  logic [pmc_pkg::CNT_W-1:0] tmr_value, it_cyc, wait_cyc;

  assign it_cyc   = (it_q == 4'h0) ? pmc_pkg::CNT_W'(pmc_pkg::IT_BASE_CYC)
                  : pmc_pkg::CNT_W'(32'(it_q) * pmc_pkg::IT_UNIT_CYC);
  assign wait_cyc = pmc_pkg::CNT_W'((32'(wait_q) + 32'd1) * WAIT_UNIT_CYC);
  assign run_ok   = on_q & ~sd_q;

  always_comb begin
    case (cmd_q)
      pmc_pkg::CMD_MEAS: rd_word = {7'h00, sd_q, cal_q, 1'b0, trig_q, mode_q, 3'h0, on_q};
      pmc_pkg::CMD_TIME: rd_word = {4'h0, it_q, wait_q};
      pmc_pkg::CMD_EMIT: rd_word = {12'h000, drv_q, cur_q};
      pmc_pkg::CMD_STAT: rd_word = {14'h0000, ms_q == pmc_pkg::MS_ACTIVE, first_q};
      default:           rd_word = 16'h0000;
    endcase
  end

  always_comb begin
    on_d      = on_q;
    mode_d    = mode_q;
    trig_d    = trig_q;
    cal_d     = 1'b0;
    sd_d      = sd_q;
    it_d      = it_q;
    wait_d    = wait_q;
    cur_d     = cur_q;
    drv_d     = drv_q;
    armed_d   = armed_q;
    first_d   = first_q;
    ms_d      = ms_q;
    done_d    = 1'b0;
    tmr_load  = 1'b0;
    tmr_value = it_cyc;
    unique case (ms_q)
      pmc_pkg::MS_IDLE: begin
        if (run_ok && (!mode_q || trig_q)) begin
          ms_d     = pmc_pkg::MS_ACTIVE;
          tmr_load = 1'b1;
        end
      end
      pmc_pkg::MS_ACTIVE: begin
        if (tmr_done) begin
          done_d = 1'b1;
          if (mode_q) begin
            ms_d   = pmc_pkg::MS_IDLE;
            trig_d = 1'b0;
          end else begin
            ms_d      = pmc_pkg::MS_WAIT;
            tmr_load  = 1'b1;
            tmr_value = wait_cyc;
          end
          if (armed_q) begin
            first_d = 1'b1;
            armed_d = 1'b0;
          end
        end
      end
      pmc_pkg::MS_WAIT: begin
        if (tmr_done || mode_q) begin
          ms_d = pmc_pkg::MS_IDLE;
        end
      end
      default: begin
        ms_d = pmc_pkg::MS_IDLE;
      end
    endcase
    // switching off aborts any measurement in progress
    if (!run_ok) begin
      ms_d = pmc_pkg::MS_IDLE;
    end
    if (stat_rd && !(first_d && !first_q)) begin
      first_d = 1'b0;  // read clears, a new detection wins
    end
    if (wr_en) begin
      unique case (cmd_q)
        pmc_pkg::CMD_MEAS: begin
          on_d   = wr_word[pmc_pkg::ON_BIT];
          mode_d = wr_word[pmc_pkg::MODE_BIT];
          sd_d   = wr_word[pmc_pkg::SD_BIT];
          cal_d  = wr_word[pmc_pkg::CAL_BIT];
          if (wr_word[pmc_pkg::TRIG_BIT]) begin
            trig_d = 1'b1;
          end
          if (sd_q && !wr_word[pmc_pkg::SD_BIT]) begin
            armed_d = 1'b1;
          end
          if (wr_word[pmc_pkg::SD_BIT]) begin
            armed_d = 1'b0;
          end
        end
        pmc_pkg::CMD_TIME: begin
          wait_d = wr_word[pmc_pkg::WAIT_LSB +: 8];
          it_d   = wr_word[pmc_pkg::IT_LSB +: 4];
        end
        pmc_pkg::CMD_EMIT: begin
          cur_d = wr_word[pmc_pkg::CUR_LSB +: 3];
          drv_d = wr_word[pmc_pkg::DRV_BIT];
        end
        default: begin
        end
      endcase
    end
    emit_d = (ms_d == pmc_pkg::MS_ACTIVE) & drv_q;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      on_q    <= pmc_pkg::ON_RST;
      mode_q  <= pmc_pkg::MODE_RST;
      trig_q  <= 1'b0;
      cal_q   <= 1'b0;
      sd_q    <= pmc_pkg::SD_RST;
      it_q    <= pmc_pkg::IT_RST;
      wait_q  <= pmc_pkg::WAIT_RST;
      cur_q   <= pmc_pkg::CUR_RST;
      drv_q   <= pmc_pkg::DRV_RST;
      armed_q <= 1'b0;
      first_q <= 1'b0;
      emit_q  <= 1'b0;
      done_q  <= 1'b0;
      ms_q    <= pmc_pkg::MS_IDLE;
    end else begin
      on_q    <= on_d;
      mode_q  <= mode_d;
      trig_q  <= trig_d;
      cal_q   <= cal_d;
      sd_q    <= sd_d;
      it_q    <= it_d;
      wait_q  <= wait_d;
      cur_q   <= cur_d;
      drv_q   <= drv_d;
      armed_q <= armed_d;
      first_q <= first_d;
      emit_q  <= emit_d;
      done_q  <= done_d;
      ms_q    <= ms_d;
    end
  end

  pmc_timer u_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .load    (tmr_load),
    .value   (tmr_value),
    .done    (tmr_done)
  );

  assign sensor_powered        = on_q;
  assign meas_active           = (ms_q == pmc_pkg::MS_ACTIVE);
  assign meas_done             = done_q;
  assign emitter_pulse         = emit_q;
  assign emitter_current_code  = cur_q;
  assign emitter_current_valid = (cur_q >= pmc_pkg::CUR_MIN_VALID);
  assign adc_wide_range        = (it_q >= pmc_pkg::IT_WIDE_MIN);
  assign factory_cal_reload    = cal_q;
  assign first_detect          = first_q;

endmodule
`default_nettype wire

// File: test/pmc_top_properties.sv
// port checker of the proximity measurement control block
`timescale 1ns/10ps
`default_nettype none
module pmc_top_properties (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       sensor_powered,
  input wire logic       meas_active,
  input wire logic       meas_done,
  input wire logic       emitter_pulse,
  input wire logic [2:0] emitter_current_code,
  input wire logic       emitter_current_valid,
  input wire logic       factory_cal_reload,
  input wire logic       first_detect
);
  // cycles of the running integration
  logic [12:0] run_q;
  logic [12:0] run_d;
  always_comb begin
    run_d = meas_active ? run_q + 13'h0001 : 13'h0000;
  end
  always_ff @(posedge ref_clk) begin
    run_q <= rst ? 13'h0000 : run_d;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  property p_valid;
    emitter_current_valid == (emitter_current_code >= 3'h2);
  endproperty
  a_valid: assert property (p_valid) else $error("current valid wrong");
  // pulse and active state are launched from the same next-state value
  property p_pulse;
    emitter_pulse |-> meas_active;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse outside measurement");
  // a switch-off may drop power one cycle before the run ends
  property p_on;
    meas_active |-> sensor_powered || $past(sensor_powered);
  endproperty
  a_on: assert property (p_on) else $error("active while off");
  property p_done1;
    meas_done |=> !meas_done;
  endproperty
  a_done1: assert property (p_done1) else $error("done too long");
  property p_done;
    meas_done |-> !meas_active && ($past(meas_active) || $past(meas_active, 2));
  endproperty
  a_done: assert property (p_done) else $error("done without run");
  property p_cal;
    factory_cal_reload |=> !factory_cal_reload;
  endproperty
  a_cal: assert property (p_cal) else $error("reload not a pulse");
  property p_len;
    $fell(meas_active) && sensor_powered |->
      run_q == 13'h00FA || (run_q % 13'h01F4 == 13'h0000 && run_q != 13'h0000);
  endproperty
  a_len: assert property (p_len) else $error("integration length wrong");
  property p_max;
    run_q <= 13'h1D4C;
  endproperty
  a_max: assert property (p_max) else $error("integration too long");
  property p_first;
    $rose(first_detect) |-> $past(meas_active) || $past(meas_active, 2);
  endproperty
  a_first: assert property (p_first) else $error("first flag not at run end");
endmodule
bind pmc_top pmc_top_properties u_props (
  .ref_clk(ref_clk), .rst(rst), .sensor_powered(sensor_powered),
  .meas_active(meas_active), .meas_done(meas_done), .emitter_pulse(emitter_pulse),
  .emitter_current_code(emitter_current_code),
  .emitter_current_valid(emitter_current_valid),
  .factory_cal_reload(factory_cal_reload), .first_detect(first_detect)
);
`default_nettype wire

// File: test/pmc_host_model.sv
// serial host model driving the register port
`timescale 1ns/10ps
`default_nettype none
module pmc_host_model #(
  parameter logic [6:0] ADDR = pmc_pkg::DEV_ADDR_DEF
) (
  input  wire logic ref_clk,
  input  wire logic sda_oe_n,
  input  wire logic sda_out,
  output var logic  scl_in,
  output wire logic sda_in
);
  logic sda_drv;
  // pull-up: wire is low while either side pulls
  assign sda_in = sda_drv & (sda_oe_n | sda_out);
  initial begin
    scl_in = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // also serves as repeated start from a low clock
  task automatic start;
    sda_drv = 1'b1;
    hw(5);
    scl_in = 1'b1;
    hw(5);
    sda_drv = 1'b0;
    hw(5);
    scl_in = 1'b0;
    hw(2);
  endtask
  task automatic stop;
    sda_drv = 1'b0;
    hw(5);
    scl_in = 1'b1;
    hw(5);
    sda_drv = 1'b1;
    hw(5);
  endtask
  // data held 2 cycles past the clock fall, so sync skew cannot smear it
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    hw(5);
    scl_in = 1'b1;
    hw(5);
    r = sda_in;
    scl_in = 1'b0;
    hw(2);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, nak);
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [15:0] v, output logic nak);
    logic [3:0] n;
    start;
    wbyte({ADDR, 1'b0}, n[0]);
    wbyte(cmd, n[1]);
    wbyte(v[7:0], n[2]);
    wbyte(v[15:8], n[3]);
    stop;
    nak = |n;
  endtask
  task automatic rd(input logic [7:0] cmd, output logic [15:0] v, output logic nak);
    logic [2:0] n;
    start;
    wbyte({ADDR, 1'b0}, n[0]);
    wbyte(cmd, n[1]);
    start;
    wbyte({ADDR, 1'b1}, n[2]);
    rbyte(1'b0, v[7:0]);
    rbyte(1'b1, v[15:8]);
    stop;
    nak = |n;
  endtask
endmodule
`default_nettype wire

// File: test/proximity_measurement_control_tb.sv
// self-checking bench of the proximity measurement control block
`timescale 1ns/10ps
`default_nettype none
module proximity_measurement_control_tb;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       scl_in, sda_in, sda_out, sda_oe_n, sensor_powered, meas_active;
  logic       meas_done, emitter_pulse, emitter_current_valid, adc_wide_range;
  logic       factory_cal_reload, first_detect;
  logic [2:0] emitter_current_code;
  int         failures = 0, check_count = 0, cyc = 0;
  int         done_n = 0, act_n = 0, pls_n = 0, cal_n = 0;
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  pmc_top #(.WAIT_UNIT_CYC(20)) DUT (
    .ref_clk(ref_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .sensor_powered(sensor_powered),
    .meas_active(meas_active), .meas_done(meas_done), .emitter_pulse(emitter_pulse),
    .emitter_current_code(emitter_current_code),
    .emitter_current_valid(emitter_current_valid), .adc_wide_range(adc_wide_range),
    .factory_cal_reload(factory_cal_reload), .first_detect(first_detect)
  );
  pmc_host_model host (.ref_clk(ref_clk), .sda_oe_n(sda_oe_n), .sda_out(sda_out),
                       .scl_in(scl_in), .sda_in(sda_in));
  task automatic end_of_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ceiling well above the longest expected run
  always @(posedge ref_clk) begin
    cyc++;
    done_n += meas_done;
    act_n += meas_active;
    pls_n += emitter_pulse;
    cal_n += factory_cal_reload;
    if (cyc == 90000) failures++;
    if (cyc == 90000) end_of_test;
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [15:0] it_cyc(input logic [3:0] c);
    return (c == 4'h0) ? 16'h00FA : 16'(c) * 16'h01F4;
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] v;
    logic        n;
    logic [3:0]  it;
    logic        drv;
    int          d0, a0, p0;
    d0 = $urandom(82);
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("reset outs", 16'h0000, {sensor_powered, meas_active, emitter_pulse, first_detect});
    host.rd(pmc_pkg::CMD_MEAS, v, n);
    chk("ctl reset", 16'h0100, v);
    host.rd(pmc_pkg::CMD_TIME, v, n);
    chk("time reset", 16'h0000, v);
    host.rd(8'h05, v, n);
    chk("unmapped", 16'h0000, {v[15:1], n});
    host.start;
    host.wbyte(8'h10, n);
    host.stop;
    chk("foreign addr nak", 16'h0001, 16'(n));
    for (int i = 0; i < 8; i++) begin
      drv = 1'($urandom);
      host.wr(pmc_pkg::CMD_EMIT, {12'h000, drv, 3'(i)}, n);
      chk("cur code", 16'(i), 16'(emitter_current_code));
      chk("cur valid", 16'(i >= 2), 16'(emitter_current_valid));
      host.rd(pmc_pkg::CMD_EMIT, v, n);
      chk("emit rb", {12'h000, drv, 3'(i)}, v);
    end
    for (int i = 0; i < 4; i++) begin
      it = (i == 0) ? 4'h7 : (i == 1) ? 4'h8 : 4'($urandom);
      host.wr(pmc_pkg::CMD_TIME, {4'h0, it, 8'h00}, n);
      chk("wide range", 16'(it >= 4'h8), 16'(adc_wide_range));
    end
    host.wr(pmc_pkg::CMD_TIME, 16'h0000, n);
    host.wr(pmc_pkg::CMD_EMIT, 16'h000A, n);
    d0 = done_n;
    host.wr(pmc_pkg::CMD_MEAS, 16'h0001, n);
    chk("powered", 16'h0001, 16'(sensor_powered));
    repeat (1500) @(negedge ref_clk);
    chk("auto repeats", 16'h0001, 16'(done_n - d0 >= 4));
    chk("first flag", 16'h0001, 16'(first_detect));
    host.wr(pmc_pkg::CMD_MEAS, 16'h0100, n);
    chk("off", 16'h0000, 16'(sensor_powered));
    host.rd(pmc_pkg::CMD_STAT, v, n);
    chk("status", 16'h0001, v);
    chk("first cleared", 16'h0000, 16'(first_detect));
    d0 = done_n;
    host.wr(pmc_pkg::CMD_MEAS, 16'h0101, n);
    repeat (800) @(negedge ref_clk);
    chk("shutdown holds", 16'h0000, 16'(done_n - d0));
    host.wr(pmc_pkg::CMD_MEAS, 16'h0011, n);
    repeat (800) @(negedge ref_clk);
    chk("single idle", 16'h0000, 16'(done_n - d0));
    for (int i = 0; i < 3; i++) begin
      it = 4'($urandom % 4);
      drv = (i != 1);
      host.wr(pmc_pkg::CMD_TIME, {4'h0, it, 8'h00}, n);
      host.wr(pmc_pkg::CMD_EMIT, {12'h000, drv, 3'h2}, n);
      d0 = done_n;
      a0 = act_n;
      p0 = pls_n;
      host.wr(pmc_pkg::CMD_MEAS, 16'h0031, n);
      for (int k = 0; k < 3000 && done_n == d0; k++) @(negedge ref_clk);
      repeat (600) @(negedge ref_clk);
      chk("one run", 16'h0001, 16'(done_n - d0));
      chk("int time", it_cyc(it), 16'(act_n - a0));
      chk("pulse width", drv ? it_cyc(it) : 16'h0000, 16'(pls_n - p0));
      host.rd(pmc_pkg::CMD_MEAS, v, n);
      chk("trig cleared", 16'h0011, v);
    end
    d0 = cal_n;
    host.wr(pmc_pkg::CMD_MEAS, 16'h0091, n);
    host.rd(pmc_pkg::CMD_MEAS, v, n);
    chk("cal pulse", 16'h0001, 16'(cal_n - d0));
    chk("cal cleared", 16'h0011, v);
    // reset in the middle of a triggered run must bring back the reset levels of power, active, pulse and first flag, and the control register
    host.wr(pmc_pkg::CMD_MEAS, 16'h0031, n);
    chk("run before reset", 16'h0001, 16'(meas_active));
    rst = 1'b1;
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("reset again", 16'h0000, {sensor_powered, meas_active, emitter_pulse, first_detect});
    host.rd(pmc_pkg::CMD_MEAS, v, n);
    chk("ctl reset again", 16'h0100, v);
    end_of_test;
  end
endmodule
`default_nettype wire
